// ### rtl/ihp_top.sv
// Purpose: Induction cooker pulse generator with comparator sync and locks
// Assumes: Comparator results arrive as digital levels synchronous to clk
// Notes:   Analog comparators consume the reference codes driven here
//
// Summary of operation
// (RULE1) The pulse width is a 10-bit value giving 1024 steps of active phase length.
// (RULE2) A sync comparator change starts a new cycle at once or after the programmed delay.
// (RULE3) Three protection channels each drive a programmable reference and can force the output safe.
// (RULE4) Sync transitions inside the blanking window are ignored as noise.
// (RULE5) A hard lock stops the output until software re-enables it; hardware cannot release it.
// (RULE6) A soft lock ends the current cycle and loads the active duty from the safe preset.
// (RULE7) The output drives the switch; active length in clock cycles sets power.
// (RULE8) The output rises on the sync crossing, stays high for the duty, then falls.
// (RULE9) Software writes the duty value to set the wanted power.
// (RULE10) All comparator actions run in hardware with no software involvement.
// (RULE11) Software enables the delayed trigger so the switch turns on near zero collector voltage.
// (RULE12) A falling edge of the surge comparator hard-locks the output at once.
// (RULE13) The over-voltage comparator soft-locks the generator at once.
// (RULE14) The safe level forced by either lock is low, keeping the switch off.
`timescale 1ns/1ps
`default_nettype none

module ihp_top
  import ihp_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              srst,
  input  wire logic [ihp_pkg::ADDR_W-1:0]        addr,
  input  wire logic [ihp_pkg::DATA_W-1:0]        wr_data,
  input  wire logic                              wr_en,
  input  wire logic                              rd_en,
  output var  logic [ihp_pkg::DATA_W-1:0]        rd_data,
  input  wire logic                              sync_compare_out,
  input  wire logic [ihp_pkg::NUM_PROT-1:0]      prot_compare_out,
  output var  logic [ihp_pkg::NUM_PROT*ihp_pkg::REF_W-1:0] prot_ref_level,
  output var  logic                              pwm_out,
  output var  logic                              hard_locked,
  output var  logic                              irq
);

  import ihp_pkg::*;

  // Software state
  ihp_ctrl_type                 ctrl;
  logic [DUTY_W-1:0]            active_duty_value;
  logic [DUTY_W-1:0]            safe_duty_preset;
  logic [DELAY_W-1:0]           delay_val;
  logic [BLANK_W-1:0]           blank_val;
  ihp_pcfg_type [NUM_PROT-1:0]  pcfg;
  logic [NUM_IRQ-1:0]           irq_stat;
  logic [NUM_IRQ-1:0]           irq_mask;

  // Engine state
  ihp_state_type                state;
  logic [DUTY_W-1:0]            high_cnt;
  logic [DELAY_W-1:0]           delay_cnt;
  logic [BLANK_W-1:0]           blank_cnt;
  logic                         sync_prev;
  logic [NUM_PROT-1:0]          prot_prev;

  // Decoded strobes and events
  logic                         wr_ctrl;
  logic                         wr_duty;
  logic                         rd_irq;
  logic                         sync_edge;
  logic                         trig_ok;
  logic                         trig_rej;
  logic [NUM_PROT-1:0]          prot_edge;
  logic [NUM_PROT-1:0]          prot_hard;
  logic [NUM_PROT-1:0]          prot_soft;
  logic                         hard_evt;
  logic                         soft_evt;
  logic                         running;
  logic                         start_now;
  logic                         start_evt;
  logic [NUM_IRQ-1:0]           irq_evt;
  logic [DATA_W-1:0]            next_rd_data;
  logic [NUM_IRQ-1:0]           next_irq_stat;

  // Reference codes held as flops so the outputs come straight from registers
  logic [REF_W-1:0]             prot_ref [NUM_PROT];

  // Write and read decode
  assign wr_ctrl = wr_en && (addr == OFF_CTRL);
  assign wr_duty = wr_en && (addr == OFF_DUTY);
  assign rd_irq  = rd_en && (addr == OFF_IRQ_STAT);

  // Generator may only run when enabled and not hard-locked
  assign running = ctrl.enable && !hard_locked;  // RULE5

  // Sync edge: rising crossing, or any change when selected
  assign sync_edge = ctrl.any_edge ? (sync_compare_out != sync_prev)
                                   : (sync_compare_out && !sync_prev);  // RULE2 RULE8

  // Noise guard: edges inside blanking or an active cycle are dropped
  assign trig_ok  = sync_edge && running && (state == IHP_IDLE) && (blank_cnt == '0);  // RULE4
  assign trig_rej = sync_edge && running && !trig_ok;  // RULE4

  // Per-channel edge detect and action decode
  genvar g;
  generate
    for (g = 0; g < NUM_PROT; g++) begin : g_prot
      assign prot_edge[g] = pcfg[g].falling ? (!prot_compare_out[g] && prot_prev[g])
                                            : (prot_compare_out[g] && !prot_prev[g]);  // RULE3
      assign prot_hard[g] = prot_edge[g] && (pcfg[g].action == ACT_HARD);  // RULE12
      assign prot_soft[g] = prot_edge[g] && (pcfg[g].action == ACT_SOFT);  // RULE13
      assign prot_ref_level[g*REF_W +: REF_W] = prot_ref[g];  // RULE3
    end
  endgenerate

  assign hard_evt = |prot_hard;  // RULE10
  assign soft_evt = |prot_soft && !hard_evt;  // RULE10

  // Immediate start or start after delay expiry
  assign start_now = trig_ok && !(ctrl.delay_en && (delay_val != '0)) && !hard_evt && !soft_evt;  // RULE2
  assign start_evt = (start_now
                      || (state == IHP_DELAY && delay_cnt == '0 && running && !hard_evt && !soft_evt))
                     && (active_duty_value != '0);

  assign irq_evt[IRQ_START]  = start_evt;
  assign irq_evt[IRQ_SOFT]   = soft_evt;
  assign irq_evt[IRQ_HARD]   = hard_evt;
  assign irq_evt[IRQ_REJECT] = trig_rej;

  // Control register; an enable write releases a hard lock
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= '0;
    end else if (wr_ctrl) begin
      ctrl.enable   <= wr_data[CTRL_ENABLE];
      ctrl.delay_en <= wr_data[CTRL_DELAY_EN];
      ctrl.any_edge <= wr_data[CTRL_ANY_EDGE];
    end
  end

  // Hard lock: set wins over a same-cycle re-enable write
  always_ff @(posedge clk) begin
    if (srst) begin
      hard_locked <= 1'b0;
    end else if (hard_evt) begin
      hard_locked <= 1'b1;  // RULE5 RULE12
    end else if (wr_ctrl && wr_data[CTRL_ENABLE]) begin
      hard_locked <= 1'b0;  // RULE5
    end
  end

  // Active duty; soft lock overrides a same-cycle software write
  always_ff @(posedge clk) begin
    if (srst) begin
      active_duty_value <= RST_DUTY;
    end else if (soft_evt) begin
      active_duty_value <= safe_duty_preset;  // RULE6 RULE13
    end else if (wr_duty) begin
      active_duty_value <= wr_data[DUTY_W-1:0];  // RULE1 RULE9
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      safe_duty_preset <= RST_SAFE;
      delay_val        <= RST_DELAY;
      blank_val        <= RST_BLANK;
      pcfg             <= RST_PCFG;
      irq_mask         <= '0;
      for (int i = 0; i < NUM_PROT; i++) begin
        prot_ref[i] <= RST_REF;
      end
    end else if (wr_en) begin
      unique case (addr)
        OFF_SAFE:     safe_duty_preset <= wr_data[DUTY_W-1:0];
        OFF_DELAY:    delay_val        <= wr_data[DELAY_W-1:0];  // RULE11
        OFF_BLANK:    blank_val        <= wr_data[BLANK_W-1:0];
        OFF_PROT_CFG: pcfg             <= wr_data[NUM_PROT*PCFG_W-1:0];
        OFF_IRQ_MASK: irq_mask         <= wr_data[NUM_IRQ-1:0];
        OFF_PROT_REF: begin
          for (int i = 0; i < NUM_PROT; i++) begin
            prot_ref[i] <= wr_data[i*REF_W +: REF_W];  // RULE3
          end
        end
        default: ;
      endcase
    end
  end

  // Input history for edge detection
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_prev <= 1'b0;
      prot_prev <= '0;
    end else begin
      sync_prev <= sync_compare_out;
      prot_prev <= prot_compare_out;
    end
  end

  // Cycle engine
  always_ff @(posedge clk) begin
    if (srst) begin
      state     <= IHP_IDLE;
      high_cnt  <= '0;
      delay_cnt <= '0;
    end else if (hard_evt || soft_evt || !running) begin
      state <= IHP_IDLE;  // RULE5 RULE6
    end else begin
      unique case (state)
        IHP_IDLE: begin
          if (start_now) begin
            state    <= (active_duty_value != '0) ? IHP_HIGH : IHP_IDLE;
            high_cnt <= active_duty_value;  // RULE8
          end else if (trig_ok) begin
            state     <= IHP_DELAY;  // RULE2
            delay_cnt <= delay_val - 8'h01;
          end
        end
        IHP_DELAY: begin
          if (delay_cnt == '0) begin
            state    <= (active_duty_value != '0) ? IHP_HIGH : IHP_IDLE;
            high_cnt <= active_duty_value;
          end else begin
            delay_cnt <= delay_cnt - 8'h01;
          end
        end
        IHP_HIGH: begin
          if (high_cnt == 10'h001) begin
            state <= IHP_IDLE;  // RULE8
          end
          high_cnt <= high_cnt - 10'h001;  // RULE7
        end
      endcase
    end
  end

  // Blanking counter starts with each accepted trigger
  always_ff @(posedge clk) begin
    if (srst) begin
      blank_cnt <= '0;
    end else if (trig_ok) begin
      blank_cnt <= blank_val;  // RULE4
    end else if (blank_cnt != '0) begin
      blank_cnt <= blank_cnt - 10'h001;
    end
  end

  // Output flop: high exactly while the engine is in its high phase
  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_out <= 1'b0;
    end else if (hard_evt || soft_evt || !running) begin
      pwm_out <= 1'b0;  // RULE14
    end else begin
      pwm_out <= start_evt || (state == IHP_HIGH && high_cnt != 10'h001);  // RULE7 RULE8
    end
  end

  // Sticky status; an event beats a clearing read
  assign next_irq_stat = (irq_stat & ~(rd_irq ? {NUM_IRQ{1'b1}} : {NUM_IRQ{1'b0}})) | irq_evt;

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & irq_mask);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rd_data = '0;
    unique case (addr)
      OFF_CTRL:     next_rd_data[2:0]           = {ctrl.any_edge, ctrl.delay_en, ctrl.enable};
      OFF_DUTY:     next_rd_data[DUTY_W-1:0]    = active_duty_value;
      OFF_SAFE:     next_rd_data[DUTY_W-1:0]    = safe_duty_preset;
      OFF_DELAY:    next_rd_data[DELAY_W-1:0]   = delay_val;
      OFF_BLANK:    next_rd_data[BLANK_W-1:0]   = blank_val;
      OFF_PROT_CFG: next_rd_data[NUM_PROT*PCFG_W-1:0] = pcfg;
      OFF_PROT_REF: next_rd_data[NUM_PROT*REF_W-1:0]  = {prot_ref[2], prot_ref[1], prot_ref[0]};
      OFF_STATE:    next_rd_data[3:0]           = {(state == IHP_DELAY), hard_locked, pwm_out, running};
      OFF_IRQ_STAT: next_rd_data[NUM_IRQ-1:0]   = irq_stat;
      OFF_IRQ_MASK: next_rd_data[NUM_IRQ-1:0]   = irq_mask;
      default:      next_rd_data                = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
    end else begin
      rd_data <= '0;
    end
  end

endmodule : ihp_top

`default_nettype wire

// ### shared/ihp_pkg.sv
// Purpose: Shared constants and types for the induction pulse generator
// Assumes: 8-bit byte address, 32-bit register data
// Notes:   Offsets are byte addresses of aligned words
package ihp_pkg;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned DUTY_W      = 10;
  localparam int unsigned DELAY_W     = 8;
  localparam int unsigned BLANK_W     = 10;
  localparam int unsigned REF_W       = 8;
  localparam int unsigned NUM_PROT    = 3;
  localparam int unsigned NUM_IRQ     = 4;

  // Register offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_DUTY      = 8'h04;
  localparam logic [7:0] OFF_SAFE      = 8'h08;
  localparam logic [7:0] OFF_DELAY     = 8'h0C;
  localparam logic [7:0] OFF_BLANK     = 8'h10;
  localparam logic [7:0] OFF_PROT_CFG  = 8'h14;
  localparam logic [7:0] OFF_PROT_REF  = 8'h18;
  localparam logic [7:0] OFF_STATE     = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h24;

  // Control field positions
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_DELAY_EN = 1;
  localparam int unsigned CTRL_ANY_EDGE = 2;

  // Protection config: three bits per channel
  localparam int unsigned PCFG_W        = 3;
  localparam logic [1:0]  ACT_NONE      = 2'h0;
  localparam logic [1:0]  ACT_SOFT      = 2'h1;
  localparam logic [1:0]  ACT_HARD      = 2'h2;

  // Interrupt bit positions
  localparam int unsigned IRQ_START     = 0;
  localparam int unsigned IRQ_SOFT      = 1;
  localparam int unsigned IRQ_HARD      = 2;
  localparam int unsigned IRQ_REJECT    = 3;

  // Reset values
  localparam logic [9:0]  RST_DUTY      = 10'h000;
  localparam logic [9:0]  RST_SAFE      = 10'h000;
  localparam logic [7:0]  RST_DELAY     = 8'h00;
  localparam logic [9:0]  RST_BLANK     = 10'h000;
  localparam logic [7:0]  RST_REF       = 8'h80;

  typedef struct packed {
    logic any_edge;
    logic delay_en;
    logic enable;
  } ihp_ctrl_type;

  typedef struct packed {
    logic       falling;
    logic [1:0] action;
  } ihp_pcfg_type;

  // Channel 0 over-voltage soft lock, channel 1 surge hard lock on falling edge, channel 2 idle
  localparam ihp_pcfg_type [NUM_PROT-1:0] RST_PCFG = '{
    '{falling: 1'b0, action: ACT_NONE},
    '{falling: 1'b1, action: ACT_HARD},
    '{falling: 1'b0, action: ACT_SOFT}
  };

  typedef enum logic [1:0] {
    IHP_IDLE,
    IHP_DELAY,
    IHP_HIGH
  } ihp_state_type;

endpackage : ihp_pkg

// ### tb/ihp_props.sv
// Purpose: Port-level checks of the induction pulse generator
// Assumes: Protection channels keep their reset configuration
// Notes:   Bound into ihp_top from tb_top
`timescale 1ns/1ps
`default_nettype none
module ihp_props
  import ihp_pkg::*;
(
  input wire logic                                  clk,
  input wire logic                                  srst,
  input wire logic [ihp_pkg::ADDR_W-1:0]            addr,
  input wire logic [ihp_pkg::DATA_W-1:0]            wr_data,
  input wire logic                                  wr_en,
  input wire logic                                  rd_en,
  input wire logic [ihp_pkg::DATA_W-1:0]            rd_data,
  input wire logic                                  sync_compare_out,
  input wire logic [ihp_pkg::NUM_PROT-1:0]          prot_compare_out,
  input wire logic [ihp_pkg::NUM_PROT*ihp_pkg::REF_W-1:0] prot_ref_level,
  input wire logic                                  pwm_out,
  input wire logic                                  hard_locked,
  input wire logic                                  irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic        sync_q;
  logic [9:0]  since_edge;
  logic [10:0] hi_cnt;
  logic        rel;
  // Only an enable write may free a hard lock
  assign rel = wr_en && addr == OFF_CTRL && wr_data[CTRL_ENABLE];
  // Edge age saturates, so a long idle span never wraps into a false start
  always_ff @(posedge clk) begin
    sync_q <= sync_compare_out;
    if (srst) since_edge <= 10'h3FF;
    else if (sync_q != sync_compare_out) since_edge <= 10'h000;
    else if (since_edge != 10'h3FF) since_edge <= since_edge + 10'h001;
  end
  // Length of the current high phase
  always_ff @(posedge clk) begin
    if (srst || !pwm_out) hi_cnt <= 11'h000;
    else hi_cnt <= hi_cnt + 11'h001;
  end
  sequence s_surge_fall; $fell(prot_compare_out[1]) && !$past(srst); endsequence
  sequence s_ov_rise; $rose(prot_compare_out[0]) && !$past(srst); endsequence
  property p_start; $rose(pwm_out) |-> since_edge <= 10'd260; endproperty
  property p_hard; s_surge_fall |=> !pwm_out && hard_locked; endproperty
  property p_soft; s_ov_rise |=> !pwm_out; endproperty
  property p_hold; hard_locked && !rel |=> hard_locked; endproperty
  property p_low; hard_locked |-> !pwm_out; endproperty
  property p_width; pwm_out |-> hi_cnt < 11'd1023; endproperty
  property p_reset; $fell(srst) |-> !pwm_out && !hard_locked && !irq && prot_ref_level == 24'h808080; endproperty
  property p_rd; !$past(rd_en) |-> rd_data == 32'h0; endproperty
  a_start: assert property (p_start) else $error("pulse began without a sync edge");
  a_hard: assert property (p_hard) else $error("surge fall did not hard lock");
  a_soft: assert property (p_soft) else $error("over voltage did not end the cycle");
  a_hold: assert property (p_hold) else $error("hard lock released by hardware");
  a_low: assert property (p_low) else $error("output high while hard locked");
  a_width: assert property (p_width) else $error("high phase beyond ten bits");
  a_reset: assert property (p_reset) else $error("outputs wrong after reset");
  a_rd: assert property (p_rd) else $error("read data outside its slot");
endmodule : ihp_props
`default_nettype wire

// ### tb/ihp_analog_model.sv
// Purpose: Comparator front end seen by the pulse generator
// Assumes: Bench commands the analog situation each cycle
// Notes:   Comparator outputs are registered like a real sampler
`timescale 1ns/1ps
`default_nettype none
module ihp_analog_model
  import ihp_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         sync_hi,
  input  wire logic                         ov_trip,
  input  wire logic                         surge_trip,
  output var  logic                         sync_compare_out,
  output var  logic [ihp_pkg::NUM_PROT-1:0] prot_compare_out
);
  // Resonance crossing, over voltage high, surge pulls its output low
  always_ff @(posedge clk) begin
    sync_compare_out    <= sync_hi;
    prot_compare_out[0] <= ov_trip;
    prot_compare_out[1] <= !surge_trip;
    prot_compare_out[2] <= 1'b0;
  end
endmodule : ihp_analog_model
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the induction pulse generator
// Assumes: Protection config stays at reset values
// Notes:   Random values come from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ihp_pkg::*;
  logic        clk, srst, wr_en, rd_en, sync_hi, ov_trip, surge_trip;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, rnd, v;
  logic        sync_compare_out, pwm_out, hard_locked, irq;
  logic [2:0]  prot_compare_out;
  logic [23:0] prot_ref_level;
  int          n_mismatch, n_tests, cyc, lat, len, d;

  ihp_top dut (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .sync_compare_out(sync_compare_out), .prot_compare_out(prot_compare_out),
    .prot_ref_level(prot_ref_level), .pwm_out(pwm_out), .hard_locked(hard_locked), .irq(irq));
  ihp_analog_model far (.clk(clk), .sync_hi(sync_hi), .ov_trip(ov_trip), .surge_trip(surge_trip),
    .sync_compare_out(sync_compare_out), .prot_compare_out(prot_compare_out));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    @(posedge clk) begin addr <= a; wr_data <= dv; wr_en <= 1'b1; end
    @(posedge clk) wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) begin addr <= a; rd_en <= 1'b1; end
    @(posedge clk) rd_en <= 1'b0;
    #1 chk(nm, e, rd_data);
  endtask : rdc
  // Raise sync once; measure edges to rise and length of the high phase
  task automatic fire();
    lat = 0;
    len = 0;
    @(posedge clk) sync_hi <= 1'b1;
    while (pwm_out !== 1'b1 && lat < 300) begin @(posedge clk); #1 lat++; end
    while (pwm_out === 1'b1 && len < 1100) begin @(posedge clk); #1 len++; end
    @(posedge clk) sync_hi <= 1'b0;
  endtask : fire
  // Sync edge that must not start a pulse
  task automatic quiet(input string nm);
    logic seen;
    seen = 1'b0;
    @(posedge clk) sync_hi <= 1'b1;
    repeat (20) begin @(posedge clk); #1 seen |= pwm_out; end
    @(posedge clk) sync_hi <= 1'b0;
    chk(nm, 32'h0, {31'h0, seen});
  endtask : quiet
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, well past the fewer than two thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin n_mismatch++; results(); end
  end

  initial begin
    {srst, wr_en, rd_en, sync_hi, ov_trip, surge_trip} = 6'b100000;
    addr = 8'h00; wr_data = 32'h0; rnd = 32'hD848;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdc("duty", OFF_DUTY, 32'h0);
    rdc("pcfg", OFF_PROT_CFG, 32'h31);
    rdc("pref", OFF_PROT_REF, 32'h808080);
    rdc("unmapped", 8'h40, 32'h0);
    $display("reset values done");
    wr(OFF_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      d = (i == 0) ? 1 : (i == 1) ? 1023 : (i == 2) ? 2 : int'(rnd[9:0] | 10'h001);
      wr(OFF_DUTY, d);
      fire();
      chk("lat", 2, lat);
      chk("len", d, len);
    end
    for (int j = 0; j < 2; j++) begin
      rnd = lfsr(rnd);
      d = (j == 0) ? 255 : int'(rnd[7:0] | 8'h01);
      wr(OFF_DELAY, d);
      wr(OFF_CTRL, 32'h3);
      fire();
      chk("dlat", d + 2, lat);
    end
    $display("width and delay done");
    wr(OFF_CTRL, 32'h1); wr(OFF_DUTY, 32'h3); wr(OFF_BLANK, 32'd40);
    rdc("stat0", OFF_IRQ_STAT, 32'h1);
    fire();
    quiet("blank");
    chk("irqm", 32'h0, irq);
    wr(OFF_IRQ_MASK, 32'h9);
    @(posedge clk); #1 chk("irq", 32'h1, irq);
    rdc("stat", OFF_IRQ_STAT, 32'h9);
    @(posedge clk); #1 chk("irqc", 32'h0, irq);
    wr(OFF_BLANK, 32'h0); wr(OFF_IRQ_MASK, 32'h0);
    $display("blanking and irq done");
    // Soft lock in mid pulse, then the safe duty drives the next cycle
    wr(OFF_SAFE, 32'h5); wr(OFF_DUTY, 32'd100);
    @(posedge clk) sync_hi <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk("pre", 32'h1, pwm_out);
    @(posedge clk) ov_trip <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("soft", 32'h0, pwm_out);
    @(posedge clk) begin ov_trip <= 1'b0; sync_hi <= 1'b0; end
    rdc("sduty", OFF_DUTY, 32'h5);
    fire();
    chk("slen", 32'h5, len);
    // Hard lock holds through a released surge until software re-enables
    @(posedge clk) surge_trip <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("hl", 32'h1, hard_locked);
    quiet("locked");
    @(posedge clk) surge_trip <= 1'b0;
    quiet("stays");
    chk("hl2", 32'h1, hard_locked);
    wr(OFF_CTRL, 32'h1);
    chk("rel", 32'h0, hard_locked);
    fire();
    chk("rlen", 32'h5, len);
    $display("locks done");
    results();
  end
endmodule : tb_top
bind ihp_top ihp_props u_props (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .sync_compare_out(sync_compare_out), .prot_compare_out(prot_compare_out),
  .prot_ref_level(prot_ref_level), .pwm_out(pwm_out), .hard_locked(hard_locked), .irq(irq));
`default_nettype wire
